//--- rtl/power_mode_pkg.sv
// Purpose: shared constants for the power mode and pin state controller
// Assumes: 8-bit special register bus, one 25 MHz clock
// Notes: offsets are the printed register addresses
//
// Function
// R1: Idle request write enters idle mode
// R2: Idle stops CPU clock, keeps peripherals, state
// R3: Both request bits together mean power-down only
// R4: Interrupt ends idle, clears request, resumes
// R5: Two general flags hold software written values
// R6: Reset pin clears idle, restarts CPU clock
// R7: Block internal RAM in reset wake window
// R8: Software avoids port writes after entry
// R9: Power-down stops oscillator, freezes clocks, keeps state
// R10: Keyboard interrupt wakes like external interrupt
// R11: Reset exit restores registers, RAM kept
// R12: Reset floats port 0, drives others high
// R13: Idle holds ports, strobes high, port0 rule
// R14: Power-down holds ports, strobes low, port0 rule
// R15: Suppress bit gates address latch strobe
// R16: Suppressed latch strobe pin weakly pulled high
// R17: Pull-up disable bit turns weak pull-ups off
// R18: Reserved bit six reads zero, never stored
// R19: Stretch bit selects 6 or 30 clocks
// R20: XRAM size field in bits four to two
// R21: External interrupt ends power-down, clears request
// R22: Reset pin ends power-down via reset sequence
package power_mode_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] AUX_CTRL_ADDR = 8'h8E;

  // ==========================================================
  // Power control fields
  localparam int IDLE_REQ_POS = 0;
  localparam int PDOWN_REQ_POS = 1;
  localparam int GFLAG_ZERO_POS = 2;
  localparam int GFLAG_ONE_POS = 3;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h10;
  localparam logic [7:0] PWR_CTRL_MASK = 8'hDF;

  // ==========================================================
  // Auxiliary control fields
  localparam int STROBE_SUPPRESS_POS = 0;
  localparam int EXT_XDATA_POS = 1;
  localparam int XRAM_SIZE_LSB = 2;
  localparam int XRAM_SIZE_MSB = 4;
  localparam int PULSE_STRETCH_POS = 5;
  localparam int PULLUP_DISABLE_POS = 7;
  localparam logic [7:0] AUX_CTRL_RESET = 8'h08;
  localparam logic [7:0] AUX_CTRL_MASK = 8'hBF;

  // ==========================================================
  // Timing counts in clock periods
  localparam logic [4:0] XDATA_SHORT_CLKS = 5'h06;
  localparam logic [4:0] XDATA_LONG_CLKS = 5'h1E;
  localparam logic [3:0] WAKE_WINDOW_CLKS = 4'h4;

  // ==========================================================
  // Operating modes
  typedef enum logic [3:0] {
    PM_RUN = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_PDOWN = 4'b0100,
    PM_WAKE = 4'b1000
  } pm_state_e;

endpackage

//--- rtl/xdata_strobe_timer.sv
// Purpose: external data read/write strobe of selectable length
// Assumes: start is a one-cycle pulse from core logic
// Notes: a start while the strobe is high is ignored
`timescale 1ns/1ps
module xdata_strobe_timer
  import power_mode_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Control
  input wire logic start_in,
  input wire logic stretch_in,
  // Strobe
  output logic strobe_out
);

  logic [4:0] left_r;
  logic long_r;

  // ==========================================================
  // Pulse counter
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      left_r <= 5'h00;
      strobe_out <= 1'b0;
      long_r <= 1'b0;
    end else if (clk_en_in) begin
      if (start_in && !strobe_out) begin
        strobe_out <= 1'b1;
        long_r <= stretch_in;
        // see R19
        left_r <= (stretch_in ? XDATA_LONG_CLKS : XDATA_SHORT_CLKS) - 5'h01;
      end else if (strobe_out) begin
        if (left_r == 5'h00) begin
          strobe_out <= 1'b0;
        end else begin
          left_r <= left_r - 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  chk_short_strobe_len: assert property ( // see R19
    @(posedge clock_in) disable iff (rst_in || !clk_en_in)
    ($rose(strobe_out) && !long_r) |-> strobe_out [*6] ##1 !strobe_out)
    else $error("short strobe not six clocks");

  chk_long_strobe_len: assert property ( // see R19
    @(posedge clock_in) disable iff (rst_in || !clk_en_in)
    ($rose(strobe_out) && long_r) |-> ##29 strobe_out ##1 !strobe_out)
    else $error("long strobe not thirty clocks");

endmodule

//--- rtl/power_mode_ctrl.sv
// Purpose: idle and power-down control, pin states, auxiliary control
// Assumes: clock_in keeps running while the oscillator enable is low
// Notes: RAM itself lives outside; only its access block is here
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module power_mode_ctrl
  import power_mode_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Reset pin and wake sources
  input wire logic reset_pin_in,
  input wire logic irq_wake_in,
  input wire logic ext_wake_in,
  input wire logic kbd_wake_in,
  // Core bus activity
  input wire logic ext_code_in,
  input wire logic xdata_move_in,
  input wire logic code_read_in,
  input wire logic ext_fetch_in,
  input wire logic xdata_start_in,
  input wire logic ale_core_in,
  input wire logic fetch_core_n_in,
  input wire logic port0_core_oe_n_in,
  // Clock and reset control
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic osc_en_out,
  output logic ram_block_out,
  output logic int_reset_out,
  // Pin control
  output logic port0_oe_n_out,
  output logic ports_force_high_out,
  output logic ports_hold_out,
  output logic ale_out,
  output logic ale_oe_n_out,
  output logic ale_pullup_out,
  output logic fetch_strobe_n_out,
  output logic weak_pullup_en_out,
  // Auxiliary settings
  output logic [2:0] xram_size_out,
  output logic ext_xdata_sel_out,
  output logic xdata_strobe_out
);

  // ==========================================================
  // Declarations
  logic rst_meta_r;
  logic rst_sync_r;
  pm_state_e state_r;
  pm_state_e state_nxt;
  logic [7:0] pwr_r;
  logic [7:0] aux_r;
  logic [3:0] wake_cnt_r;
  logic wr_pwr;
  logic wr_aux;
  logic rd_pwr;
  logic rd_aux;
  logic hold_rst;
  logic wake_done;
  logic sfr_clear;
  logic leaving;
  logic ale_needed;
  logic port0_oe_n_nxt;
  logic ale_nxt;
  logic ale_oe_n_nxt;
  logic ale_pullup_nxt;
  logic fetch_strobe_n_nxt;
  logic hold_nxt;

  // ==========================================================
  // Reset pin synchroniser
  // Pin is asynchronous; two flops before any use
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else if (clk_en_in) begin
      rst_meta_r <= reset_pin_in;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================
  // Decode
  assign wr_pwr = reg_wr_in && (reg_addr_in == PWR_CTRL_ADDR);
  assign wr_aux = reg_wr_in && (reg_addr_in == AUX_CTRL_ADDR);
  assign rd_pwr = reg_rd_in && (reg_addr_in == PWR_CTRL_ADDR);
  assign rd_aux = reg_rd_in && (reg_addr_in == AUX_CTRL_ADDR);
  assign hold_rst = rst_sync_r && (state_r == PM_RUN);
  assign wake_done = (state_r == PM_WAKE) &&
                     (wake_cnt_r == WAKE_WINDOW_CLKS - 4'h1);
  // see R11
  assign sfr_clear = hold_rst || wake_done;
  assign leaving = (state_r != state_nxt) &&
                   ((state_r == PM_IDLE) || (state_r == PM_PDOWN));

  // ==========================================================
  // Mode sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PM_RUN: begin
        if (wr_pwr && !sfr_clear) begin
          if (reg_wdata_in[PDOWN_REQ_POS]) begin
            state_nxt = PM_PDOWN; // see R3
          end else if (reg_wdata_in[IDLE_REQ_POS]) begin
            state_nxt = PM_IDLE; // see R1
          end
        end
      end
      PM_IDLE: begin
        if (rst_sync_r) begin
          state_nxt = PM_WAKE; // see R6
        end else if (irq_wake_in) begin
          state_nxt = PM_RUN; // see R4
        end
      end
      PM_PDOWN: begin
        if (rst_sync_r) begin
          state_nxt = PM_WAKE; // see R22
        end else if (ext_wake_in || kbd_wake_in) begin
          state_nxt = PM_RUN; // see R10 see R21
        end
      end
      PM_WAKE: begin
        if (wake_done) begin
          state_nxt = PM_RUN;
        end
      end
      default: begin
        state_nxt = PM_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= PM_RUN;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  // Execution continues briefly before internal reset takes over
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wake_cnt_r <= 4'h0;
    end else if (clk_en_in) begin
      if (state_r == PM_WAKE) begin
        wake_cnt_r <= wake_cnt_r + 4'h1;
      end else begin
        wake_cnt_r <= 4'h0;
      end
    end
  end

  // ==========================================================
  // Power control register
  // A clear can meet a write in run (hold_rst); the clear takes priority
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pwr_r <= PWR_CTRL_RESET;
    end else if (clk_en_in) begin
      if (sfr_clear) begin
        pwr_r <= PWR_CTRL_RESET; // see R11
      end else if (leaving) begin
        // Both bits drop so power-down never falls into idle
        pwr_r[IDLE_REQ_POS] <= 1'b0; // see R3 see R4 see R6
        pwr_r[PDOWN_REQ_POS] <= 1'b0; // see R21
      end else if (wr_pwr) begin
        pwr_r <= reg_wdata_in & PWR_CTRL_MASK; // see R5
      end
    end
  end

  // ==========================================================
  // Auxiliary control register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      aux_r <= AUX_CTRL_RESET;
    end else if (clk_en_in) begin
      if (sfr_clear) begin
        aux_r <= AUX_CTRL_RESET;
      end else if (wr_aux) begin
        aux_r <= reg_wdata_in & AUX_CTRL_MASK; // see R18
      end
    end
  end

  assign xram_size_out = aux_r[XRAM_SIZE_MSB:XRAM_SIZE_LSB]; // see R20
  assign ext_xdata_sel_out = aux_r[EXT_XDATA_POS];

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      weak_pullup_en_out <= 1'b1;
    end else if (clk_en_in) begin
      weak_pullup_en_out <= !aux_r[PULLUP_DISABLE_POS]; // see R17
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      if (rd_pwr) begin
        reg_rdata_out <= pwr_r & PWR_CTRL_MASK;
      end else if (rd_aux) begin
        reg_rdata_out <= aux_r & AUX_CTRL_MASK; // see R18
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Clock, oscillator and RAM gating
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cpu_clk_en_out <= 1'b1;
      periph_clk_en_out <= 1'b1;
      osc_en_out <= 1'b1;
      ram_block_out <= 1'b0;
      int_reset_out <= 1'b0;
    end else if (clk_en_in) begin
      // see R2
      cpu_clk_en_out <= (state_nxt == PM_RUN) || (state_nxt == PM_WAKE);
      periph_clk_en_out <= (state_nxt != PM_PDOWN); // see R9
      osc_en_out <= (state_nxt != PM_PDOWN); // see R9
      ram_block_out <= (state_nxt == PM_WAKE); // see R7
      int_reset_out <= sfr_clear; // see R22
    end
  end

  // ==========================================================
  // Pin states
  assign ale_needed = xdata_move_in || code_read_in || ext_fetch_in;

  always_comb begin
    port0_oe_n_nxt = port0_core_oe_n_in;
    hold_nxt = 1'b0;
    ale_nxt = ale_core_in;
    ale_oe_n_nxt = 1'b0;
    ale_pullup_nxt = 1'b0;
    fetch_strobe_n_nxt = fetch_core_n_in;
    unique case (state_r)
      PM_IDLE: begin
        port0_oe_n_nxt = ext_code_in; // see R13
        hold_nxt = 1'b1;
        ale_nxt = 1'b1;
        fetch_strobe_n_nxt = 1'b1;
      end
      PM_PDOWN: begin
        port0_oe_n_nxt = ext_code_in; // see R14
        hold_nxt = 1'b1;
        ale_nxt = 1'b0;
        fetch_strobe_n_nxt = 1'b0;
      end
      PM_RUN, PM_WAKE: begin
        if (aux_r[STROBE_SUPPRESS_POS] && !ale_needed) begin
          // Released pin, weak pull-up keeps it high; see R15 see R16
          ale_nxt = 1'b1;
          ale_oe_n_nxt = 1'b1;
          ale_pullup_nxt = 1'b1;
        end
      end
      default: begin
        hold_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      port0_oe_n_out <= 1'b1;
      ports_force_high_out <= 1'b1;
      ports_hold_out <= 1'b0;
      ale_out <= 1'b1;
      ale_oe_n_out <= 1'b0;
      ale_pullup_out <= 1'b0;
      fetch_strobe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (hold_rst) begin
        // see R12
        port0_oe_n_out <= 1'b1;
        ports_force_high_out <= 1'b1;
        ports_hold_out <= 1'b0;
        ale_out <= 1'b1;
        ale_oe_n_out <= 1'b0;
        ale_pullup_out <= 1'b0;
        fetch_strobe_n_out <= 1'b1;
      end else begin
        port0_oe_n_out <= port0_oe_n_nxt;
        ports_force_high_out <= 1'b0;
        ports_hold_out <= hold_nxt;
        ale_out <= ale_nxt;
        ale_oe_n_out <= ale_oe_n_nxt;
        ale_pullup_out <= ale_pullup_nxt;
        fetch_strobe_n_out <= fetch_strobe_n_nxt;
      end
    end
  end

  // ==========================================================
  // External data strobe
  xdata_strobe_timer u_strobe (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .start_in(xdata_start_in),
    .stretch_in(aux_r[PULSE_STRETCH_POS]),
    .strobe_out(xdata_strobe_out)
  );

  // ==========================================================
  // Checks
  chk_idle_entry: assert property ( // see R1
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_RUN && wr_pwr && !sfr_clear &&
     reg_wdata_in[IDLE_REQ_POS] && !reg_wdata_in[PDOWN_REQ_POS])
    |=> (state_r == PM_IDLE && !cpu_clk_en_out && periph_clk_en_out))
    else $error("idle request did not enter idle");

  chk_cpu_clock_gate: assert property ( // see R2
    @(posedge clock_in) disable iff (rst_in)
    cpu_clk_en_out == (state_r == PM_RUN || state_r == PM_WAKE))
    else $error("cpu clock enable disagrees with mode");

  chk_pdown_priority: assert property ( // see R3
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_RUN && wr_pwr && !sfr_clear &&
     reg_wdata_in[IDLE_REQ_POS] && reg_wdata_in[PDOWN_REQ_POS])
    |=> state_r == PM_PDOWN)
    else $error("both requests did not give power-down");

  chk_pdown_exit_clean: assert property ( // see R21
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_PDOWN && ext_wake_in && !rst_sync_r)
    |=> (state_r == PM_RUN && pwr_r[1:0] == 2'b00))
    else $error("power-down exit left request bits");

  chk_idle_irq_exit: assert property ( // see R4
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_IDLE && irq_wake_in && !rst_sync_r)
    |=> (!pwr_r[IDLE_REQ_POS] && cpu_clk_en_out))
    else $error("interrupt did not end idle");

  chk_gflag_hold: assert property ( // see R5
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && wr_pwr && !sfr_clear && state_r == PM_RUN)
    |=> pwr_r[GFLAG_ONE_POS:GFLAG_ZERO_POS] ==
        $past(reg_wdata_in[GFLAG_ONE_POS:GFLAG_ZERO_POS]))
    else $error("general flags not stored");

  chk_reset_wake: assert property ( // see R6
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_IDLE && rst_sync_r)
    |=> (!pwr_r[IDLE_REQ_POS] && ram_block_out && cpu_clk_en_out))
    else $error("reset pin did not wake from idle");

  chk_osc_stop: assert property ( // see R9
    @(posedge clock_in) disable iff (rst_in)
    osc_en_out == (state_r != PM_PDOWN))
    else $error("oscillator enable disagrees with mode");

  chk_kbd_wake: assert property ( // see R10
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_PDOWN && kbd_wake_in && !rst_sync_r)
    |=> state_r == PM_RUN)
    else $error("keyboard wake ignored");

  chk_pdown_pins: assert property ( // see R14
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_PDOWN) |=> (!ale_out && !fetch_strobe_n_out))
    else $error("strobes not low in power-down");

  chk_strobe_suppress: assert property ( // see R16
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_r == PM_RUN && !hold_rst && !ale_needed &&
     aux_r[STROBE_SUPPRESS_POS]) |=> (ale_oe_n_out && ale_pullup_out))
    else $error("latch strobe not released");

endmodule

//--- dv/xmem_model.sv
// Purpose: external data memory seen through its read/write strobe
// Assumes: strobe is high for the whole access, one clock domain
// Notes: reports the length in clocks of the last finished strobe
`timescale 1ns/1ps
module xmem_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Strobe from the device
  input wire logic strobe_in,
  // Measured length
  output logic [7:0] pulse_len_out
);
  // ==========================================================
  // Strobe length measurement
  logic [7:0] count_r;

  // Observes only; never drives the port or data lines
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_r <= 8'h00;
      pulse_len_out <= 8'h00;
    end else if (strobe_in) begin
      count_r <= count_r + 8'h01;
    end else begin
      if (count_r != 8'h00) begin
        pulse_len_out <= count_r;
      end
      count_r <= 8'h00;
    end
  end
endmodule

//--- dv/power_mode_and_pin_state_control_tb_top.sv
// Purpose: self-checking bench for the power mode and pin controller
// Assumes: 25 MHz clock, register port with read data one cycle later
// Notes: core strobe inputs tied; ale_core_in toggles every cycle
`timescale 1ns/1ps
module power_mode_and_pin_state_control_tb_top
  import power_mode_pkg::*;
;
  // ==========================================================
  // Signals
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic reset_pin_in = 1'b0;
  logic irq_wake_in = 1'b0;
  logic ext_wake_in = 1'b0;
  logic kbd_wake_in = 1'b0;
  logic ext_code_in = 1'b0;
  logic xdata_move_in = 1'b0;
  logic xdata_start_in = 1'b0;
  logic ale_core_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [7:0] reg_rdata_out;
  logic cpu_clk_en_out, periph_clk_en_out, osc_en_out, ram_block_out;
  logic int_reset_out, port0_oe_n_out, ports_force_high_out;
  logic ports_hold_out, ale_out, ale_oe_n_out, ale_pullup_out;
  logic fetch_strobe_n_out, weak_pullup_en_out, ext_xdata_sel_out;
  logic xdata_strobe_out;
  logic [2:0] xram_size_out;
  logic [7:0] pulse_len;
  int err_total = 0;
  int tests_run = 0;

  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) ale_core_in <= ~ale_core_in;

  power_mode_ctrl DUT (
    .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reset_pin_in(reset_pin_in),
    .irq_wake_in(irq_wake_in), .ext_wake_in(ext_wake_in),
    .kbd_wake_in(kbd_wake_in), .ext_code_in(ext_code_in),
    .xdata_move_in(xdata_move_in), .code_read_in(1'b0),
    .ext_fetch_in(1'b0), .xdata_start_in(xdata_start_in),
    .ale_core_in(ale_core_in), .fetch_core_n_in(1'b0),
    .port0_core_oe_n_in(1'b0), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .osc_en_out(osc_en_out),
    .ram_block_out(ram_block_out), .int_reset_out(int_reset_out),
    .port0_oe_n_out(port0_oe_n_out),
    .ports_force_high_out(ports_force_high_out),
    .ports_hold_out(ports_hold_out), .ale_out(ale_out),
    .ale_oe_n_out(ale_oe_n_out), .ale_pullup_out(ale_pullup_out),
    .fetch_strobe_n_out(fetch_strobe_n_out),
    .weak_pullup_en_out(weak_pullup_en_out),
    .xram_size_out(xram_size_out), .ext_xdata_sel_out(ext_xdata_sel_out),
    .xdata_strobe_out(xdata_strobe_out)
  );

  xmem_model xmem (
    .clock_in(clock_in), .rst_in(rst_in),
    .strobe_in(xdata_strobe_out), .pulse_len_out(pulse_len)
  );

  // ==========================================================
  // Tasks
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask

  // One-cycle wake pulse: 0 irq, 1 external, 2 keyboard
  task automatic wake(input int src);
    @(posedge clock_in);
    if (src == 0) irq_wake_in <= 1'b1;
    if (src == 1) ext_wake_in <= 1'b1;
    if (src == 2) kbd_wake_in <= 1'b1;
    @(posedge clock_in);
    irq_wake_in <= 1'b0;
    ext_wake_in <= 1'b0;
    kbd_wake_in <= 1'b0;
    cyc(2);
  endtask

  // ==========================================================
  // Watchdog: the whole run needs well under 1000 cycles
  initial begin
    #(40 * 5000);
    err_total++;
    conclude();
  end

  // ==========================================================
  // Tests
  initial begin
    cyc(5);
    chk(port0_oe_n_out, 1'b1);
    chk(ports_force_high_out, 1'b1);
    chk({ale_out, fetch_strobe_n_out}, 2'b11);
    @(posedge clock_in);
    rst_in <= 1'b0;
    rdchk(PWR_CTRL_ADDR, 8'h10);
    rdchk(AUX_CTRL_ADDR, 8'h08);
    rdchk(8'h55, 8'h00);
    $display("Test reset values done");

    wr(AUX_CTRL_ADDR, 8'hFF);
    cyc(2);
    chk(weak_pullup_en_out, 1'b0);
    chk(xram_size_out, 3'h7);
    chk(ext_xdata_sel_out, 1'b1);
    rdchk(AUX_CTRL_ADDR, 8'hBF);
    wr(AUX_CTRL_ADDR, 8'h08);
    cyc(2);
    chk(weak_pullup_en_out, 1'b1);
    wr(PWR_CTRL_ADDR, 8'hFC);
    rdchk(PWR_CTRL_ADDR, 8'hDC);
    wr(PWR_CTRL_ADDR, 8'h00);
    $display("Test register fields done");

    wr(PWR_CTRL_ADDR, 8'h05);
    cyc(2);
    chk({cpu_clk_en_out, periph_clk_en_out, osc_en_out}, 3'b011);
    chk({ports_hold_out, ale_out, fetch_strobe_n_out}, 3'b111);
    chk(port0_oe_n_out, 1'b0);
    @(posedge clock_in);
    ext_code_in <= 1'b1;
    cyc(2);
    chk(port0_oe_n_out, 1'b1);
    // Frozen clock enable must swallow the wake pulse
    @(posedge clock_in);
    ext_code_in <= 1'b0;
    clk_en_in <= 1'b0;
    wake(0);
    chk(cpu_clk_en_out, 1'b0);
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    wake(0);
    chk(cpu_clk_en_out, 1'b1);
    rdchk(PWR_CTRL_ADDR, 8'h04);
    $display("Test idle done");

    for (int i = 0; i < 2; i++) begin
      wr(PWR_CTRL_ADDR, (i == 0) ? 8'h03 : 8'h02);
      cyc(2);
      chk({cpu_clk_en_out, periph_clk_en_out, osc_en_out}, 3'b000);
      chk({ports_hold_out, ale_out, fetch_strobe_n_out}, 3'b100);
      chk(port0_oe_n_out, 1'b0);
      @(posedge clock_in);
      ext_code_in <= 1'b1;
      cyc(2);
      chk(port0_oe_n_out, 1'b1);
      @(posedge clock_in);
      ext_code_in <= 1'b0;
      wake(i + 1);
      chk({cpu_clk_en_out, periph_clk_en_out, osc_en_out}, 3'b111);
      rdchk(PWR_CTRL_ADDR, 8'h00);
    end
    $display("Test power-down done");

    for (int i = 0; i < 2; i++) begin
      wr(AUX_CTRL_ADDR, 8'hA1);
      wr(PWR_CTRL_ADDR, (i == 0) ? 8'h01 : 8'h02);
      cyc(3);
      @(posedge clock_in);
      reset_pin_in <= 1'b1;
      for (int k = 0; k < 20 && ram_block_out !== 1'b1; k++) cyc(1);
      chk(ram_block_out, 1'b1);
      chk({cpu_clk_en_out, osc_en_out}, 2'b11);
      for (int k = 0; k < 20 && int_reset_out !== 1'b1; k++) cyc(1);
      chk(int_reset_out, 1'b1);
      @(posedge clock_in);
      reset_pin_in <= 1'b0;
      cyc(6);
      chk(ram_block_out, 1'b0);
      chk(ports_force_high_out, 1'b0);
      rdchk(AUX_CTRL_ADDR, 8'h08);
      rdchk(PWR_CTRL_ADDR, 8'h10);
    end
    $display("Test reset pin wake done");

    // Second start mid-strobe must not lengthen the pulse
    for (int s = 0; s < 2; s++) begin
      wr(AUX_CTRL_ADDR, (s == 0) ? 8'h08 : 8'h28);
      @(posedge clock_in);
      xdata_start_in <= 1'b1;
      @(posedge clock_in);
      xdata_start_in <= 1'b0;
      cyc(3);
      @(posedge clock_in);
      xdata_start_in <= 1'b1;
      @(posedge clock_in);
      xdata_start_in <= 1'b0;
      cyc(35);
      chk(pulse_len, (s == 0) ? 8'h06 : 8'h1E);
    end
    $display("Test strobe length done");

    wr(AUX_CTRL_ADDR, 8'h09);
    cyc(2);
    chk({ale_oe_n_out, ale_pullup_out, ale_out}, 3'b111);
    @(posedge clock_in);
    xdata_move_in <= 1'b1;
    cyc(2);
    chk({ale_oe_n_out, ale_pullup_out}, 2'b00);
    @(posedge clock_in);
    xdata_move_in <= 1'b0;
    wr(AUX_CTRL_ADDR, 8'h08);
    cyc(2);
    chk(ale_oe_n_out, 1'b0);
    $display("Test latch strobe suppress done");
    conclude();
  end
endmodule
